// >>> arc_defs.svh
// Constants of the auto restart controller: timing, register offsets, bit positions
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

// ==========================================================
// Timing
`define ARC_CLK_PERIOD_NS 100
`define ARC_TICK_PERIOD_NS 1000000
`define ARC_HOLD_MIN_MS 3000
`define ARC_HOLD_MAX_MS 10000
`define ARC_BLINK_MS 5000
`define ARC_FLASH_HALF_MS 100
`define ARC_BEEP_PHASE_MS 100
`define ARC_BEEP_COUNT 3
`define ARC_RESTART_DELAY_S 180

// ==========================================================
// Register offsets (byte addresses)
`define ARC_CTRL_OFS 4'h0
`define ARC_STATUS_OFS 4'h4

// ==========================================================
// Control register bits
`define ARC_CTRL_TIMER_ARM_BIT 0
`define ARC_CTRL_FILTER_SET_BIT 1

// ==========================================================
// Status register bits
`define ARC_ST_RUN_BIT 0
`define ARC_ST_RESTART_EN_BIT 1
`define ARC_ST_FILTER_BIT 2
`define ARC_ST_TIMER_BIT 3
`define ARC_ST_WAIT_BIT 4
`define ARC_ST_OUTAGE_BIT 5
`define ARC_ST_HOLDING_BIT 6

// ==========================================================
// Reset values
`define ARC_RESTART_EN_RST 1'b0
`define ARC_RUN_RST 1'b0

`endif

// >>> arc_pkg.sv
// Types of the auto restart controller
package arc_pkg;

	// ==========================================================
	// Mains supervision states, one-hot
	typedef enum logic [2:0] {
		ARC_PWR_ON = 3'b001,
		ARC_PWR_LOST = 3'b010,
		ARC_PWR_WAIT = 3'b100
	} arc_pwr_t;

	// ==========================================================
	// Front panel and remote commands
	typedef struct packed {
		logic button;
		logic remote_toggle;
		logic remote_on;
		logic remote_off;
	} arc_cmd_t;

	// ==========================================================
	// Operating and indicator outputs
	typedef struct packed {
		logic run;
		logic led_green;
		logic led_filter;
		logic beep;
		logic timer_active;
	} arc_ind_t;

endpackage : arc_pkg

// >>> arc_ctrl.sv
// Auto restart controller with panel button, remote commands and Wishbone registers
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "arc_defs.svh"

module arc_ctrl #(
	parameter int TICK_CYCLES = `ARC_TICK_PERIOD_NS / `ARC_CLK_PERIOD_NS,
	// Ticks per millisecond first, so that no product leaves the int range
	parameter int HOLD_MIN_TICKS = `ARC_HOLD_MIN_MS * (1000000 / `ARC_TICK_PERIOD_NS),
	parameter int HOLD_MAX_TICKS = `ARC_HOLD_MAX_MS * (1000000 / `ARC_TICK_PERIOD_NS),
	parameter int BLINK_TICKS = `ARC_BLINK_MS * (1000000 / `ARC_TICK_PERIOD_NS),
	parameter int FLASH_TICKS = `ARC_FLASH_HALF_MS * (1000000 / `ARC_TICK_PERIOD_NS),
	parameter int BEEP_TICKS = `ARC_BEEP_PHASE_MS * (1000000 / `ARC_TICK_PERIOD_NS),
	parameter int RESTART_TICKS = `ARC_RESTART_DELAY_S * 1000 * (1000000 / `ARC_TICK_PERIOD_NS)
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Panel, remote and mains
	input wire arc_pkg::arc_cmd_t cmd_i,
	input wire logic mains_ok_i,
	input wire logic filter_due_i,
	// Operating and indicator outputs
	output arc_pkg::arc_ind_t ind_o
);

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int HW = $clog2(HOLD_MAX_TICKS + 1);
	localparam int BW = $clog2(BLINK_TICKS + 1);
	localparam int FW = $clog2(FLASH_TICKS + BEEP_TICKS + 1);
	localparam int RW = $clog2(RESTART_TICKS + 1);

	generate
		if (TICK_CYCLES < 1 || HOLD_MIN_TICKS < 1 || HOLD_MIN_TICKS >= HOLD_MAX_TICKS ||
			FLASH_TICKS < 1 || BEEP_TICKS < 1 || BLINK_TICKS < 1 || RESTART_TICKS < 1) begin : g_chk
			$error("arc_ctrl: timing parameters out of range");
		end
	endgenerate

	// ==========================================================
	// Register decode
	function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] ofs);
		reg_hit = (adr[3:2] == ofs[3:2]);
	endfunction : reg_hit

	// ==========================================================
	// State
	logic [TW-1:0] tick_cnt_reg;
	logic tick_reg;
	logic btn_reg;
	logic [HW-1:0] hold_reg;
	logic press_swallowed_reg;
	logic run_reg;
	logic saved_run_reg;
	logic restart_en_reg;
	logic filter_reg;
	logic timer_reg;
	arc_pkg::arc_pwr_t pwr_reg;
	logic [RW-1:0] wait_reg;
	logic [BW-1:0] blink_reg;
	logic [FW-1:0] flash_cnt_reg;
	logic flash_reg;
	logic [2:0] beep_phase_reg;
	logic [FW-1:0] beep_cnt_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	arc_pkg::arc_ind_t ind_reg;

	logic press;
	logic release_ev;
	logic hold_ok;
	logic powered;
	logic wr;
	logic filter_set_wr;

	assign powered = (pwr_reg == arc_pkg::ARC_PWR_ON) || (pwr_reg == arc_pkg::ARC_PWR_WAIT);
	assign press = powered && cmd_i.button && !btn_reg;
	assign release_ev = powered && !cmd_i.button && btn_reg;
	// A hold ending inside the window, not after a filter-clear press
	assign hold_ok = release_ev && !press_swallowed_reg &&
		(hold_reg >= HW'(HOLD_MIN_TICKS)) && (hold_reg < HW'(HOLD_MAX_TICKS));
	assign wr = cyc_i && stb_i && we_i && !ack_reg;
	assign filter_set_wr = wr && reg_hit(adr_i, `ARC_CTRL_OFS) && sel_i[0] &&
		dat_i[`ARC_CTRL_FILTER_SET_BIT];

	// ==========================================================
	// Free-running tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Button hold measurement, saturating at the upper limit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			btn_reg <= 1'b0;
			hold_reg <= '0;
			press_swallowed_reg <= 1'b0;
		end else begin
			btn_reg <= cmd_i.button;
			if (press) begin
				hold_reg <= '0;
				press_swallowed_reg <= filter_reg;
			end else if (btn_reg && tick_reg && hold_reg != HW'(HOLD_MAX_TICKS)) begin
				hold_reg <= hold_reg + 1'b1;
			end
		end
	end

	// ==========================================================
	// Mains supervision
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_reg <= arc_pkg::ARC_PWR_ON;
			wait_reg <= '0;
			saved_run_reg <= 1'b0;
		end else begin
			case (pwr_reg)
				arc_pkg::ARC_PWR_ON: begin
					if (!mains_ok_i) begin
						pwr_reg <= arc_pkg::ARC_PWR_LOST;
						saved_run_reg <= run_reg;
					end
				end
				arc_pkg::ARC_PWR_LOST: begin
					wait_reg <= '0;
					if (mains_ok_i) begin
						if (restart_en_reg && saved_run_reg) begin
							pwr_reg <= arc_pkg::ARC_PWR_WAIT;
						end else begin
							pwr_reg <= arc_pkg::ARC_PWR_ON;
						end
					end
				end
				arc_pkg::ARC_PWR_WAIT: begin
					if (!mains_ok_i) begin
						pwr_reg <= arc_pkg::ARC_PWR_LOST;
					end else if (cmd_i.remote_on || cmd_i.remote_off || cmd_i.remote_toggle ||
						press) begin
						// An explicit command overrides the pending resume
						pwr_reg <= arc_pkg::ARC_PWR_ON;
					end else if (wait_reg == RW'(RESTART_TICKS)) begin
						pwr_reg <= arc_pkg::ARC_PWR_ON;
					end else if (tick_reg) begin
						wait_reg <= wait_reg + 1'b1;
					end
				end
				default: pwr_reg <= arc_pkg::ARC_PWR_ON;
			endcase
		end
	end

	// ==========================================================
	// Run state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_reg <= `ARC_RUN_RST;
		end else if (!mains_ok_i || pwr_reg == arc_pkg::ARC_PWR_LOST) begin
			run_reg <= 1'b0;
		end else if (pwr_reg == arc_pkg::ARC_PWR_WAIT && wait_reg == RW'(RESTART_TICKS) &&
			!(cmd_i.remote_on || cmd_i.remote_off || cmd_i.remote_toggle || press)) begin
			run_reg <= 1'b1;
		end else if (press && !filter_reg) begin
			run_reg <= !run_reg;
		end else if (cmd_i.remote_toggle) begin
			run_reg <= !run_reg;
		end else if (cmd_i.remote_on) begin
			run_reg <= 1'b1;
		end else if (cmd_i.remote_off) begin
			run_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Restart enable flag, filter indication and timer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			restart_en_reg <= `ARC_RESTART_EN_RST;
		end else if (hold_ok) begin
			restart_en_reg <= !restart_en_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filter_reg <= 1'b0;
		end else if (filter_due_i || filter_set_wr) begin
			filter_reg <= 1'b1; // Set wins over a clearing press in the same cycle
		end else if (press) begin
			filter_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_reg <= 1'b0;
		end else if (pwr_reg == arc_pkg::ARC_PWR_LOST || !mains_ok_i) begin
			timer_reg <= 1'b0;
		end else if (wr && reg_hit(adr_i, `ARC_CTRL_OFS) && sel_i[0]) begin
			timer_reg <= dat_i[`ARC_CTRL_TIMER_ARM_BIT];
		end
	end

	// ==========================================================
	// Acknowledge: three beeps and a five second blink
	always_ff @(posedge clk_i) begin
		if (rst_i || !powered) begin
			beep_phase_reg <= '0;
			beep_cnt_reg <= '0;
		end else if (hold_ok) begin
			beep_phase_reg <= 3'(2 * `ARC_BEEP_COUNT);
			beep_cnt_reg <= '0;
		end else if (beep_phase_reg != '0 && tick_reg) begin
			if (beep_cnt_reg == FW'(BEEP_TICKS - 1)) begin
				beep_cnt_reg <= '0;
				beep_phase_reg <= beep_phase_reg - 1'b1;
			end else begin
				beep_cnt_reg <= beep_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !powered) begin
			blink_reg <= '0;
			flash_cnt_reg <= '0;
			flash_reg <= 1'b0;
		end else if (hold_ok) begin
			blink_reg <= BW'(BLINK_TICKS);
			flash_cnt_reg <= '0;
			flash_reg <= 1'b1;
		end else if (blink_reg != '0 && tick_reg) begin
			blink_reg <= blink_reg - 1'b1;
			if (flash_cnt_reg == FW'(FLASH_TICKS - 1)) begin
				flash_cnt_reg <= '0;
				flash_reg <= !flash_reg;
			end else begin
				flash_cnt_reg <= flash_cnt_reg + 1'b1;
			end
		end
	end

	// ==========================================================
	// Indicator outputs, registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ind_reg <= '0;
		end else begin
			ind_reg.run <= run_reg;
			// Blink overrides the steady run lamp while it lasts
			ind_reg.led_green <= (blink_reg != '0) ? flash_reg : run_reg;
			ind_reg.led_filter <= filter_reg;
			ind_reg.beep <= beep_phase_reg[0];
			ind_reg.timer_active <= timer_reg;
		end
	end

	assign ind_o = ind_reg;

	// ==========================================================
	// Wishbone slave: one wait state, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= cyc_i && stb_i && !ack_reg;
			dat_reg <= '0;
			if (cyc_i && stb_i && !we_i && !ack_reg) begin
				if (reg_hit(adr_i, `ARC_CTRL_OFS)) begin
					dat_reg[`ARC_CTRL_TIMER_ARM_BIT] <= timer_reg;
				end else if (reg_hit(adr_i, `ARC_STATUS_OFS)) begin
					dat_reg[`ARC_ST_RUN_BIT] <= run_reg;
					dat_reg[`ARC_ST_RESTART_EN_BIT] <= restart_en_reg;
					dat_reg[`ARC_ST_FILTER_BIT] <= filter_reg;
					dat_reg[`ARC_ST_TIMER_BIT] <= timer_reg;
					dat_reg[`ARC_ST_WAIT_BIT] <= (pwr_reg == arc_pkg::ARC_PWR_WAIT);
					dat_reg[`ARC_ST_OUTAGE_BIT] <= (pwr_reg == arc_pkg::ARC_PWR_LOST);
					dat_reg[`ARC_ST_HOLDING_BIT] <= btn_reg;
				end
			end
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

endmodule : arc_ctrl

// >>> arc_ctrl_props.sv
// Port checker of the auto restart controller
`timescale 1ns/1ps

// ==========================================================
// Checker
module arc_ctrl_props (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Panel, mains and outputs
	input wire arc_pkg::arc_cmd_t cmd_i,
	input wire logic mains_ok_i,
	input wire logic filter_due_i,
	input wire arc_pkg::arc_ind_t ind_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_press;
		$rose(cmd_i.button) && mains_ok_i && !ind_o.led_filter && !filter_due_i;
	endsequence
	sequence s_fpress;
		$rose(cmd_i.button) && mains_ok_i && ind_o.led_filter && !filter_due_i;
	endsequence

	a_reset_clean: assert property (disable iff (1'b0) rst_i |=> ind_o == '0 && !ack_o)
		else $error("outputs not clear after reset");
	a_press_toggle: assert property (s_press |-> ##2 ind_o.run != $past(ind_o.run, 2))
		else $error("press did not switch run");
	a_filter_only: assert property (s_fpress |=> $stable(ind_o.run)[*3] ##0 !ind_o.led_filter)
		else $error("filter press misbehaved");
	a_outage_run: assert property (!mains_ok_i[*3] |-> !ind_o.run)
		else $error("running during outage");
	a_outage_timer: assert property (!mains_ok_i[*3] |-> !ind_o.timer_active)
		else $error("timer kept over outage");
	a_no_early: assert property ($rose(mains_ok_i) |-> !ind_o.run[*8])
		else $error("restart without delay");
	a_beep_phase: assert property ($rose(ind_o.beep) |-> ind_o.beep[*3])
		else $error("beep too short");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing");
	a_idle_data: assert property (!ack_o |-> dat_o == '0)
		else $error("read data outside ack");
endmodule : arc_ctrl_props

// >>> arc_panel.sv
// Panel button and remote model driving the command inputs
`timescale 1ns/1ps

// ==========================================================
// Panel model
module arc_panel (
	// Clock
	input wire logic clk_i,
	// Commands to the controller
	output arc_pkg::arc_cmd_t cmd_o
);
	initial cmd_o = '0;

	task automatic hold(input int n);
		cmd_o.button <= 1'b1;
		repeat (n) @(posedge clk_i);
		cmd_o.button <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : hold

	// One-cycle remote pulse: bits are toggle, on, off
	task automatic remote(input logic [2:0] c);
		{cmd_o.remote_toggle, cmd_o.remote_on, cmd_o.remote_off} <= c;
		@(posedge clk_i);
		{cmd_o.remote_toggle, cmd_o.remote_on, cmd_o.remote_off} <= 3'b000;
		repeat (2) @(posedge clk_i);
	endtask : remote
endmodule : arc_panel

// >>> tb_top.sv
// Self-checking testbench of the auto restart controller
`timescale 1ns/1ps

// ==========================================================
// Bench
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic mains_ok_i = 1'b1;
	logic filter_due_i = 1'b0;
	arc_pkg::arc_cmd_t cmd_i;
	arc_pkg::arc_ind_t ind_o;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h3ebc742b;
	logic run_m = 1'b0, flag_m = 1'b0, filt_m = 1'b0, tmr_m = 1'b0;
	int num_errors = 0;
	int samples_checked = 0;
	int beeps = 0;
	int flips = 0;

	initial forever #50 clk_i = ~clk_i;

	// Short counts keep the run brief
	arc_ctrl #(.TICK_CYCLES(4), .HOLD_MIN_TICKS(3), .HOLD_MAX_TICKS(10), .BLINK_TICKS(5),
		.FLASH_TICKS(1), .BEEP_TICKS(1), .RESTART_TICKS(18)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .cmd_i(cmd_i), .mains_ok_i(mains_ok_i),
		.filter_due_i(filter_due_i), .ind_o(ind_o));
	arc_panel panel (.clk_i(clk_i), .cmd_o(cmd_i));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic fail(input string m);
		num_errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail

	task automatic chk(input logic c, input string m);
		samples_checked++;
		if (c !== 1'b1) fail(m);
	endtask : chk

	// Wishbone classic cycle, waits for ack under a bound
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail("bus timeout");
			end_sim();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0, 4'(rnd()));
	endtask : rd

	// Status read, then the indicator outputs against the same model
	task automatic st(input logic [1:0] ow);
		rd(4'h4, {25'h0, 1'b0, ow, tmr_m, filt_m, flag_m, run_m});
		chk(ind_o.run === run_m && ind_o.led_green === run_m, "run lamp");
		chk(ind_o.led_filter === filt_m && ind_o.timer_active === tmr_m, "lamps");
	endtask : st

	// Valid hold: run switches at the press, flag at the release
	task automatic toggle();
		beeps = 0;
		panel.hold(4 * (4 + rnd() % 5));
		run_m = !run_m;
		flips = 0;
		repeat (60) @(posedge clk_i);
		chk(beeps == 3, "beep count");
		chk(flips >= 4, "no blink");
		flag_m = !flag_m;
		st(2'b00);
	endtask : toggle

	// Read results leave the queue in issue order
	always @(posedge clk_i) begin
		if ($rose(ind_o.beep)) beeps++;
		if ($changed(ind_o.led_green)) flips++;
		if (ack_o === 1'b1 && we_i === 1'b0) begin
			samples_checked++;
			if (exp_q.size() == 0) begin
				fail("unexpected read");
			end else begin
				if (dat_o !== exp_q[0]) fail("read data");
				void'(exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		st(2'b00);
		rd(4'h8, 32'h0);
		tmr_m = 1'b1;
		wb(1'b1, 4'h0, (rnd() & 32'hfffffffc) | 32'h1, 4'(rnd()) | 4'h1);
		rd(4'h0, 32'h1);
		// Lane 0 disabled: the write must leave the control bits alone
		wb(1'b1, 4'h0, rnd(), 4'(rnd()) & 4'he);
		rd(4'h0, 32'h1);
		panel.hold(4);
		run_m = 1'b1;
		st(2'b00);
		toggle();
		panel.hold(4);
		run_m = 1'b1;
		st(2'b00);
		mains_ok_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		run_m = 1'b0;
		tmr_m = 1'b0;
		st(2'b10);
		mains_ok_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		st(2'b01);
		repeat (100) @(posedge clk_i);
		run_m = 1'b1;
		st(2'b00);
		toggle();
		beeps = 0;
		panel.hold(48);
		run_m = 1'b1;
		repeat (60) @(posedge clk_i);
		chk(beeps == 0, "long hold beeped");
		st(2'b00);
		mains_ok_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		run_m = 1'b0;
		mains_ok_i <= 1'b1;
		repeat (100) @(posedge clk_i);
		st(2'b00);
		panel.remote(3'b010);
		run_m = 1'b1;
		st(2'b00);
		panel.remote(3'b100);
		run_m = 1'b0;
		st(2'b00);
		panel.remote(3'b100);
		run_m = 1'b1;
		st(2'b00);
		panel.remote(3'b001);
		run_m = 1'b0;
		st(2'b00);
		panel.remote(3'b010);
		run_m = 1'b1;
		st(2'b00);
		filter_due_i <= 1'b1;
		@(posedge clk_i);
		filter_due_i <= 1'b0;
		@(posedge clk_i);
		filt_m = 1'b1;
		st(2'b00);
		panel.hold(4);
		filt_m = 1'b0;
		st(2'b00);
		wb(1'b1, 4'h0, 32'h2, 4'h1);
		filt_m = 1'b1;
		st(2'b00);
		panel.hold(4);
		filt_m = 1'b0;
		st(2'b00);
		// Enable restart, which also stops the run, then reset: the flag must come back cleared
		toggle();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		run_m = 1'b0;
		flag_m = 1'b0;
		st(2'b00);
		end_sim();
	end
endmodule : tb_top

bind arc_ctrl arc_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .cmd_i(cmd_i), .mains_ok_i(mains_ok_i), .filter_due_i(filter_due_i),
	.ind_o(ind_o));
